//--- mfas_regs.svh
// offsets, field positions, reset values and fixed codes of the flow action selector
// assumes inclusion by the package and the design module only
`ifndef MFAS_REGS_SVH
`define MFAS_REGS_SVH

// register byte offsets (apb, one aligned word each)
`define MFAS_OFF_EGR_ACT      12'h000
`define MFAS_OFF_IGR_ACT      12'h004
`define MFAS_OFF_NM_NCP       12'h008
`define MFAS_OFF_NM_CP        12'h00c
`define MFAS_OFF_CTRL         12'h010
`define MFAS_OFF_STATUS       12'h014

// common action fields
`define MFAS_F_TYPE_LO        0
`define MFAS_F_PORT_LO        2
`define MFAS_F_DROP_LO        4
// egress action fields
`define MFAS_E_PROTECT        6
`define MFAS_E_ACTIVE         7
`define MFAS_E_SCI            8
`define MFAS_E_ES             9
`define MFAS_E_SCB            10
`define MFAS_E_BYP_LO         11
`define MFAS_E_COFS_LO        13
`define MFAS_E_CONF           20
// ingress action fields
`define MFAS_I_DROP_NRES      6
`define MFAS_I_REPLAY         7
`define MFAS_I_ACTIVE         8
`define MFAS_I_VAL_LO         9
`define MFAS_I_COFS_LO        11
// nomatch: 4 bytes per register, one per tag class, fields as action bits 5:0
`define MFAS_NM_STRIDE        8
// ctrl register: bit 0 direction (1 egress), bits 4:1 header size in 2-byte units
`define MFAS_C_EGRESS         0
`define MFAS_C_HSZ_LO         1

// reset values
`define MFAS_RST_ACT          32'h0000_0000
`define MFAS_RST_CTRL         32'h0000_0000

// fixed flow type codes
`define MFAS_FT_BYPASS        2'h0
`define MFAS_FT_DROP          2'h1
`define MFAS_FT_PROCESS       2'h2
// destination ports
`define MFAS_PORT_RESERVED    2'h1
// drop handling codes
`define MFAS_DROP_CRC         2'h0
`define MFAS_DROP_PKTERR      2'h1
`define MFAS_DROP_INTERNAL    2'h2
// header bypass sizes in 2-byte units
`define MFAS_HSZ_MAX          4'h8

`endif

//--- mfas_pkg.sv
// types shared by the flow action selector
// assumes mfas_regs.svh in the include path
package mfas_pkg;
	`include "mfas_regs.svh"

	typedef enum logic [1:0] {
		MFAS_TAG_UNTAGGED = 2'h0,
		MFAS_TAG_TAGGED   = 2'h1,
		MFAS_TAG_BAD      = 2'h2,
		MFAS_TAG_KAY      = 2'h3
	} mfas_tag_class_type;
endpackage

//--- mfas_flow_action_select.sv
// flow action selector: applies sa or nomatch action to each looked-up frame
// assumes one lookup result per cycle, inputs synchronous to pclk
// ****************************************************************
// Overview of operation
// - each action carries a 2-bit destination port output with the frame
// - each action holds a 2-bit drop-handling field
// - egress protect bit 1 protects, 0 passes through crypto unprotected
// - each flow action carries a 1-bit association active indicator; unmatched actions have none, their output is 0
// - egress bit selects explicit or implicit sci in the tag
// - egress 2-bit count of 0, 1 or 2 bypassed vlan tags
// - egress 7-bit authenticated-only offset plus confidentiality enable
// - ingress 7-bit authenticated but undecrypted offset
// - ingress bit drops packets not from the reserved port
// - ingress bit enables replay protection
// - ingress 2-bit validation level: disabled, check or strict
// - process flows fetch sequence, keys and sci from stored context
// - unmatched packets sort into eight categories, each with own action
// - unmatched actions only pass or drop, with port and drop method
// - egress bypass count zero gives standard protection
// - ingress bypassed tag count comes from parser and sectag position
// - key agreement packets detected and bypassed in both directions
// - bypassed vlan tags excluded from encryption and authentication
// - header bypass: sectag after ethernet header plus 2 to 16 bytes
// - drop: forward with crc mark, packet error mark, or drop internally
// - header size zero means no bypassed header
// - one header size for all ports, 2 to 16 bytes in steps of two
// ****************************************************************
//
// Added by the designer: the address map and the APB interface to the registers.
`include "mfas_regs.svh"
module mfas_flow_action_select
	import mfas_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// lookup result
	input  wire logic        lk_valid,
	input  wire logic        lk_sa_hit,
	input  wire logic        lk_control,
	input  wire logic [1:0]  lk_tag_class,
	input  wire logic [1:0]  lk_src_port,
	input  wire logic [1:0]  lk_vlan_count,
	// pipeline output
	output logic             act_valid,
	output logic [1:0]       act_flow_type,
	output logic [1:0]       act_dest_port,
	output logic             act_drop_crc,
	output logic             act_drop_pkterr,
	output logic             act_drop_internal,
	output logic             act_protect,
	output logic             act_use_context,
	output logic             act_association_active,
	output logic             act_sci_explicit,
	output logic             act_end_station_bit_en,
	output logic             act_scb_bit_en,
	output logic [1:0]       act_tag_bypass,
	output logic [6:0]       act_conf_offset,
	output logic             act_conf_protect,
	output logic             act_replay_protect,
	output logic [1:0]       act_validate_level,
	output logic [4:0]       act_header_bytes
);
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_check
		$error("mfas: ADDR_W out of range");
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	logic [31:0] egr_r;
	logic [31:0] igr_r;
	logic [31:0] ncp_r;
	logic [31:0] cp_r;
	logic [31:0] ctrl_r;
	logic [31:0] frames_r;

	wire         wr_acc = psel && penable && pwrite && clk_en;
	wire [11:0]  a12    = 12'(paddr);
	wire         hit_e  = (a12 == `MFAS_OFF_EGR_ACT);
	wire         hit_i  = (a12 == `MFAS_OFF_IGR_ACT);
	wire         hit_n  = (a12 == `MFAS_OFF_NM_NCP);
	wire         hit_c  = (a12 == `MFAS_OFF_NM_CP);
	wire         hit_k  = (a12 == `MFAS_OFF_CTRL);
	wire         hit_s  = (a12 == `MFAS_OFF_STATUS);
	wire         mapped = hit_e | hit_i | hit_n | hit_c | hit_k | hit_s;
	wire [31:0]  bmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// header size kept in 2-byte units, capped so only 0 and 2..16 bytes exist
	wire [3:0]   hsz_wr  = pwdata[`MFAS_C_HSZ_LO +: 4];
	wire [3:0]   hsz_ok  = (hsz_wr > `MFAS_HSZ_MAX) ? `MFAS_HSZ_MAX : hsz_wr;
	wire [31:0]  ctrl_wd = {27'h0, hsz_ok, pwdata[`MFAS_C_EGRESS]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			egr_r  <= `MFAS_RST_ACT;
			igr_r  <= `MFAS_RST_ACT;
			ncp_r  <= `MFAS_RST_ACT;
			cp_r   <= `MFAS_RST_ACT;
			ctrl_r <= `MFAS_RST_CTRL;
		end else if (wr_acc) begin
			if (hit_e) egr_r <= merge(egr_r, pwdata, bmask);
			if (hit_i) igr_r <= merge(igr_r, pwdata, bmask);
			if (hit_n) ncp_r <= merge(ncp_r, pwdata, bmask);
			if (hit_c) cp_r  <= merge(cp_r, pwdata, bmask);
			if (hit_k && pstrb[0]) ctrl_r <= ctrl_wd;
		end
	end

	// unmapped addresses answer with pslverr and zero data
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = hit_e ? egr_r : hit_i ? igr_r : hit_n ? ncp_r : hit_c ? cp_r :
	                 hit_k ? ctrl_r : hit_s ? frames_r : 32'h0;

	// ****************************************************************
	// action selection
	// ****************************************************************
	wire         egress  = ctrl_r[`MFAS_C_EGRESS];
	wire [3:0]   hsz     = ctrl_r[`MFAS_C_HSZ_LO +: 4];
	wire [31:0]  sa_act  = egress ? egr_r : igr_r;
	// four classes per register, selected by control bit and tag class
	wire [31:0]  nm_reg  = lk_control ? cp_r : ncp_r;
	wire [7:0]   nm_byte = nm_reg[lk_tag_class*`MFAS_NM_STRIDE +: 8];
	wire         is_kay  = (lk_tag_class == MFAS_TAG_KAY);
	wire [5:0]   base    = lk_sa_hit ? sa_act[5:0] : nm_byte[5:0];
	wire [1:0]   raw_ft  = base[`MFAS_F_TYPE_LO +: 2];
	// unmatched flows may only pass or drop, any other code passes
	wire [1:0]   nm_ft   = (raw_ft == `MFAS_FT_DROP) ? `MFAS_FT_DROP : `MFAS_FT_BYPASS;
	wire [1:0]   ft0     = lk_sa_hit ? raw_ft : nm_ft;
	// key agreement frames never enter the transform
	wire [1:0]   ft1     = (is_kay && ft0 == `MFAS_FT_PROCESS) ? `MFAS_FT_BYPASS : ft0;
	wire         nres    = !egress && lk_sa_hit && igr_r[`MFAS_I_DROP_NRES]
	                       && (lk_src_port != `MFAS_PORT_RESERVED);
	wire [1:0]   ft      = nres ? `MFAS_FT_DROP : ft1;
	wire [1:0]   drop_m  = base[`MFAS_F_DROP_LO +: 2];
	wire         dropping = (ft == `MFAS_FT_DROP);
	wire         proc     = (ft == `MFAS_FT_PROCESS);
	wire         eproc    = proc && egress;
	wire         iproc    = proc && !egress;
	// egress takes the configured count, ingress the parser count before the sectag
	wire [1:0]   ebyp    = (egr_r[`MFAS_E_BYP_LO +: 2] > 2'h2) ? 2'h2 : egr_r[`MFAS_E_BYP_LO +: 2];
	wire [1:0]   ibyp    = (lk_vlan_count > 2'h2) ? 2'h2 : lk_vlan_count;
	wire [1:0]   byp     = egress ? ebyp : ibyp;
	wire [4:0]   hbytes  = {hsz, 1'b0};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_valid              <= 1'b0;
			act_flow_type          <= `MFAS_FT_BYPASS;
			act_dest_port          <= 2'h0;
			act_drop_crc           <= 1'b0;
			act_drop_pkterr        <= 1'b0;
			act_drop_internal      <= 1'b0;
			act_protect            <= 1'b0;
			act_use_context        <= 1'b0;
			act_association_active <= 1'b0;
			act_sci_explicit       <= 1'b0;
			act_end_station_bit_en <= 1'b0;
			act_scb_bit_en         <= 1'b0;
			act_tag_bypass         <= 2'h0;
			act_conf_offset        <= 7'h0;
			act_conf_protect       <= 1'b0;
			act_replay_protect     <= 1'b0;
			act_validate_level     <= 2'h0;
			act_header_bytes       <= 5'h0;
			frames_r               <= 32'h0;
		end else if (clk_en) begin
			act_valid <= lk_valid;
			if (lk_valid) begin
				frames_r               <= frames_r + 32'h1;
				act_flow_type          <= ft;
				act_dest_port          <= base[`MFAS_F_PORT_LO +: 2];
				act_drop_crc           <= dropping && drop_m == `MFAS_DROP_CRC;
				act_drop_pkterr        <= dropping && drop_m == `MFAS_DROP_PKTERR;
				act_drop_internal      <= dropping && drop_m == `MFAS_DROP_INTERNAL;
				act_protect            <= eproc && egr_r[`MFAS_E_PROTECT];
				act_use_context        <= proc;
				act_association_active <= lk_sa_hit && (egress ? egr_r[`MFAS_E_ACTIVE]
				                                               : igr_r[`MFAS_I_ACTIVE]);
				act_sci_explicit       <= eproc && egr_r[`MFAS_E_SCI];
				act_end_station_bit_en <= eproc && egr_r[`MFAS_E_ES];
				act_scb_bit_en         <= eproc && egr_r[`MFAS_E_SCB];
				act_tag_bypass         <= proc ? byp : 2'h0;
				act_conf_offset        <= eproc ? egr_r[`MFAS_E_COFS_LO +: 7] :
				                          iproc ? igr_r[`MFAS_I_COFS_LO +: 7] : 7'h0;
				act_conf_protect       <= eproc && egr_r[`MFAS_E_CONF];
				act_replay_protect     <= iproc && igr_r[`MFAS_I_REPLAY];
				act_validate_level     <= iproc ? igr_r[`MFAS_I_VAL_LO +: 2] : 2'h0;
				act_header_bytes       <= hbytes;
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_valid_follows: assert property (clk_en |=> act_valid == $past(lk_valid))
		else $error("act_valid does not follow lk_valid");
	a_nomatch_no_process: assert property (clk_en && lk_valid && !lk_sa_hit
		|=> act_flow_type != `MFAS_FT_PROCESS && !act_use_context)
		else $error("unmatched frame got a transform");
	a_kay_bypassed: assert property (clk_en && lk_valid && !nres
		&& lk_tag_class == MFAS_TAG_KAY |=> act_flow_type != `MFAS_FT_PROCESS)
		else $error("key agreement frame processed");
	a_drop_one_hot: assert property ($onehot0({act_drop_crc, act_drop_pkterr,
		act_drop_internal}))
		else $error("more than one drop mark");
	a_nonres_drop: assert property (clk_en && lk_valid && nres
		|=> act_flow_type == `MFAS_FT_DROP)
		else $error("non reserved frame not dropped");
	a_bypass_max: assert property (act_tag_bypass <= 2'h2)
		else $error("tag bypass above two");
	a_protect_egress: assert property (act_protect |-> act_flow_type == `MFAS_FT_PROCESS)
		else $error("protect outside egress process");
	a_hdr_size: assert property (act_header_bytes <= 5'h10 && !act_header_bytes[0])
		else $error("header size illegal");
	a_frame_count: assert property (clk_en && lk_valid
		|=> frames_r == $past(frames_r) + 32'h1)
		else $error("frame counter stuck");

	// register bus and clock enable
	a_write_lands: assert property (wr_acc && hit_e && pstrb == 4'hf
		|=> egr_r == $past(pwdata))
		else $error("egress write lost");
	a_ctrl_clamp: assert property (wr_acc && hit_k && pstrb[0]
		|=> ctrl_r[`MFAS_C_HSZ_LO +: 4] <= `MFAS_HSZ_MAX)
		else $error("header size above limit");
	a_frozen_regs: assert property (!clk_en
		|=> $stable(egr_r) && $stable(igr_r) && $stable(ctrl_r))
		else $error("register moved while frozen");
	a_frozen_out: assert property (!clk_en
		|=> $stable(act_valid) && $stable(frames_r))
		else $error("output moved while frozen");
	a_hold_fields: assert property (!(clk_en && lk_valid)
		|=> $stable(act_flow_type) && $stable(act_dest_port))
		else $error("fields moved without lookup");

	// common fields
	a_port_follows: assert property (clk_en && lk_valid
		|=> act_dest_port == $past(base[`MFAS_F_PORT_LO +: 2]))
		else $error("port not forwarded");
	a_type_follows: assert property (clk_en && lk_valid
		|=> act_flow_type == $past(ft))
		else $error("flow type not forwarded");
	a_drop_crc: assert property (clk_en && lk_valid && dropping
		&& drop_m == `MFAS_DROP_CRC |=> act_drop_crc)
		else $error("crc mark missing");
	a_drop_pkterr: assert property (clk_en && lk_valid && dropping
		&& drop_m == `MFAS_DROP_PKTERR |=> act_drop_pkterr)
		else $error("packet error mark missing");
	a_drop_internal: assert property (clk_en && lk_valid && dropping
		&& drop_m == `MFAS_DROP_INTERNAL |=> act_drop_internal)
		else $error("internal drop missing");
	a_drop_only_drop: assert property (act_drop_crc || act_drop_pkterr
		|| act_drop_internal |-> act_flow_type == `MFAS_FT_DROP)
		else $error("drop mark without drop");

	// unmatched frames
	a_nm_ctrl_drop: assert property (clk_en && lk_valid && !lk_sa_hit && lk_control
		&& cp_r[lk_tag_class*`MFAS_NM_STRIDE +: 2] == `MFAS_FT_DROP
		|=> act_flow_type == `MFAS_FT_DROP)
		else $error("control class drop ignored");
	a_nm_data_drop: assert property (clk_en && lk_valid && !lk_sa_hit && !lk_control
		&& ncp_r[lk_tag_class*`MFAS_NM_STRIDE +: 2] == `MFAS_FT_DROP
		|=> act_flow_type == `MFAS_FT_DROP)
		else $error("data class drop ignored");
	a_nm_port: assert property (clk_en && lk_valid && !lk_sa_hit
		|=> act_dest_port == $past(nm_byte[`MFAS_F_PORT_LO +: 2]))
		else $error("unmatched port lost");
	a_active_nomatch: assert property (clk_en && lk_valid && !lk_sa_hit
		|=> !act_association_active)
		else $error("unmatched frame active");

	// egress transform
	a_protect_set: assert property (clk_en && lk_valid && eproc
		&& egr_r[`MFAS_E_PROTECT] |=> act_protect)
		else $error("protection not applied");
	a_protect_clear: assert property (clk_en && lk_valid && eproc
		&& !egr_r[`MFAS_E_PROTECT] |=> !act_protect && act_use_context)
		else $error("unprotected frame left crypto");
	a_active_egr: assert property (clk_en && lk_valid && lk_sa_hit && egress
		|=> act_association_active == $past(egr_r[`MFAS_E_ACTIVE]))
		else $error("egress active wrong");
	a_sci_follows: assert property (clk_en && lk_valid && eproc
		|=> act_sci_explicit == $past(egr_r[`MFAS_E_SCI]))
		else $error("sci mode not forwarded");
	a_sci_egress: assert property (act_sci_explicit
		|-> act_flow_type == `MFAS_FT_PROCESS && act_use_context)
		else $error("sci mode outside process");
	a_es_follows: assert property (clk_en && lk_valid && eproc
		|=> act_end_station_bit_en == $past(egr_r[`MFAS_E_ES]))
		else $error("es enable not forwarded");
	a_scb_follows: assert property (clk_en && lk_valid && eproc
		|=> act_scb_bit_en == $past(egr_r[`MFAS_E_SCB]))
		else $error("scb enable not forwarded");
	a_bypass_zero: assert property (clk_en && lk_valid && eproc
		&& egr_r[`MFAS_E_BYP_LO +: 2] == 2'h0 |=> act_tag_bypass == 2'h0)
		else $error("tags bypassed at zero");
	a_bypass_egress: assert property (clk_en && lk_valid && eproc
		&& egr_r[`MFAS_E_BYP_LO +: 2] <= 2'h2
		|=> act_tag_bypass == $past(egr_r[`MFAS_E_BYP_LO +: 2]))
		else $error("egress bypass wrong");
	a_conf_egress: assert property (clk_en && lk_valid && eproc
		|=> act_conf_offset == $past(egr_r[`MFAS_E_COFS_LO +: 7])
		&& act_conf_protect == $past(egr_r[`MFAS_E_CONF]))
		else $error("egress confidentiality wrong");

	// ingress transform
	a_active_igr: assert property (clk_en && lk_valid && lk_sa_hit && !egress
		|=> act_association_active == $past(igr_r[`MFAS_I_ACTIVE]))
		else $error("ingress active wrong");
	a_reserved_kept: assert property (clk_en && lk_valid && lk_sa_hit && !egress
		&& !is_kay && lk_src_port == `MFAS_PORT_RESERVED
		|=> act_flow_type == $past(raw_ft))
		else $error("reserved frame altered");
	a_bypass_ingress: assert property (clk_en && lk_valid && iproc
		&& lk_vlan_count <= 2'h2 |=> act_tag_bypass == $past(lk_vlan_count))
		else $error("ingress bypass wrong");
	a_bypass_noproc: assert property (clk_en && lk_valid && !proc
		|=> act_tag_bypass == 2'h0)
		else $error("bypass outside transform");
	a_conf_ingress: assert property (clk_en && lk_valid && iproc
		|=> act_conf_offset == $past(igr_r[`MFAS_I_COFS_LO +: 7]) && !act_conf_protect)
		else $error("ingress offset wrong");
	a_replay_follows: assert property (clk_en && lk_valid && iproc
		|=> act_replay_protect == $past(igr_r[`MFAS_I_REPLAY]))
		else $error("replay not forwarded");
	a_replay_ingress: assert property (act_replay_protect
		|-> act_flow_type == `MFAS_FT_PROCESS && !act_protect)
		else $error("replay outside ingress");
	a_validate_follows: assert property (clk_en && lk_valid && iproc
		|=> act_validate_level == $past(igr_r[`MFAS_I_VAL_LO +: 2]))
		else $error("validation not forwarded");
	a_validate_egress: assert property (clk_en && lk_valid && !iproc
		|=> act_validate_level == 2'h0)
		else $error("validation outside ingress");
	a_context_proc: assert property (act_use_context
		== (act_flow_type == `MFAS_FT_PROCESS))
		else $error("context use mismatch");

	// header bypass
	a_hdr_follows: assert property (clk_en && lk_valid
		|=> act_header_bytes == $past(hbytes))
		else $error("header size not forwarded");
	a_hdr_zero: assert property (clk_en && lk_valid && hsz == 4'h0
		|=> act_header_bytes == 5'h0)
		else $error("header at size zero");

	c_sa_process: cover property (lk_valid && lk_sa_hit ##1 act_use_context);
	c_nm_drop: cover property (lk_valid && !lk_sa_hit ##1 act_flow_type == `MFAS_FT_DROP);
	c_kay: cover property (lk_valid && lk_tag_class == MFAS_TAG_KAY);
	c_hdr: cover property (act_valid && act_header_bytes != 5'h0);
	c_nres: cover property (lk_valid && nres);
endmodule

//--- mfas_mac_sink.sv
// mac side sink: counts the frames that reach the packet path
// assumes act_* come registered from the selector, one pulse per frame
// ****************************************
// frame counter
// ****************************************
module mfas_mac_sink (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// pipeline output
	input  wire logic        act_valid,
	input  wire logic        act_drop_internal,
	// observation
	output logic      [31:0] frames
);
	timeunit 1ns;
	timeprecision 1ns;
	// an internal drop never shows at the mac, so it must not be counted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frames <= 32'h0;
		else if (act_valid && !act_drop_internal)
			frames <= frames + 32'h1;
	end
endmodule

//--- tb_top.sv
// self-checking bench of the flow action selector, apb master and frame model
// assumes act_* one cycle after each lookup; the apb master waits for pready
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mfas_pkg::*;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic        lk_valid, lk_sa_hit, lk_control, act_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, egr_m, igr_m, ncp_m, cp_m, ctrl_m, rd, a, frames;
	logic [3:0]  pstrb;
	logic [1:0]  lk_tag_class, lk_src_port, lk_vlan_count;
	logic [15:0] seed;
	logic        er;
	wire  [30:0] got;
	int          n_errors, samples_checked, exp_frames, n_lookups, i;
	// ****************************************
	// design and mac side
	// ****************************************
	mfas_flow_action_select mfas_flow_action_select_i (.pclk, .presetn, .clk_en, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .lk_valid,
		.lk_sa_hit, .lk_control, .lk_tag_class, .lk_src_port, .lk_vlan_count, .act_valid,
		.act_flow_type(got[30:29]), .act_dest_port(got[28:27]), .act_drop_crc(got[26]),
		.act_drop_pkterr(got[25]), .act_drop_internal(got[24]), .act_protect(got[23]),
		.act_use_context(got[22]), .act_association_active(got[21]),
		.act_sci_explicit(got[20]), .act_end_station_bit_en(got[19]),
		.act_scb_bit_en(got[18]), .act_tag_bypass(got[17:16]), .act_conf_offset(got[15:9]),
		.act_conf_protect(got[8]), .act_replay_protect(got[7]),
		.act_validate_level(got[6:5]), .act_header_bytes(got[4:0]));
	mfas_mac_sink mfas_mac_sink_i (.pclk, .presetn, .act_valid, .act_drop_internal(got[24]),
		.frames);
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd[15:0] = seed;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd[31:16] = seed;
	endfunction
	// expected outputs worked out from the shadow registers
	function automatic logic [30:0] model(input logic h, c, input logic [1:0] cl, s, v);
		logic [31:0] x;
		logic [5:0]  n;
		logic [1:0]  t, tb;
		logic        eg, p;
		eg = ctrl_m[0];
		n = (c ? cp_m : ncp_m) >> (8 * cl);
		x = h ? (eg ? egr_m : igr_m) : {26'h0, n[5:2], (n[1:0] == 2'h1) ? 2'h1 : 2'h0};
		t = x[1:0];
		if (h && cl == 2'h3 && t == 2'h2) t = 2'h0;
		if (h && !eg && x[6] && s != 2'h1) t = 2'h1;
		p = (t == 2'h2);
		tb = eg ? x[12:11] : v;
		tb = !p ? 2'h0 : (tb > 2'h2) ? 2'h2 : tb;
		return {t, x[3:2], t == 2'h1 && x[5:4] == 2'h0, t == 2'h1 && x[5:4] == 2'h1,
			t == 2'h1 && x[5:4] == 2'h2, p & eg & x[6], p, h & (eg ? x[7] : x[8]),
			p & eg & x[8], p & eg & x[9], p & eg & x[10], tb,
			!p ? 7'h0 : eg ? x[19:13] : x[17:11],
			p & eg & x[20], p & !eg & x[7], (p & !eg) ? x[10:9] : 2'h0,
			(ctrl_m[4:1] > 4'h8) ? 5'h10 : {ctrl_m[4:1], 1'b0}};
	endfunction
	task automatic chk_act(input string nm, input logic [30:0] e, g, m);
		samples_checked++;
		if (((g ^ e) & m) !== 31'h0) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_reg(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		input logic [3:0] st);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		pstrb <= st;
		penable <= 0;
		@(posedge pclk) penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic wreg(input logic [11:0] ad, input logic [31:0] d);
		apb(1, ad, d, 4'hf);
		case (ad)
			12'h000: egr_m = d;
			12'h004: igr_m = d;
			12'h008: ncp_m = d;
			12'h00c: cp_m = d;
			default: ctrl_m = d;
		endcase
	endtask
	task automatic send(input logic h, c, input logic [1:0] cl, s, v);
		logic [30:0] e;
		e = model(h, c, cl, s, v);
		{lk_sa_hit, lk_control, lk_tag_class, lk_src_port, lk_vlan_count} <= {h, c, cl, s, v};
		lk_valid <= 1;
		@(posedge pclk) lk_valid <= 0;
		#1;
		chk_reg("act_valid", {31'h0, clk_en}, {31'h0, act_valid});
		if (clk_en) begin
			chk_act("action", e, got, {31{1'b1}});
			n_lookups++;
			if (!e[24]) exp_frames++;
		end
		@(posedge pclk);
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		clk_en = 1'b1;
		{lk_valid, lk_sa_hit, lk_control, lk_tag_class, lk_src_port, lk_vlan_count} = 0;
		{egr_m, igr_m, ncp_m, cp_m, ctrl_m} = 0;
		seed = 16'h000c;
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (i = 0; i < 7; i++) begin
			apb(0, 12'(i * 4), 0, 0);
			chk_reg("reset or unmapped", 0, rd);
			chk_reg("slave error", {31'h0, i == 6}, {31'h0, er});
		end
		$display("test reset_regs done");
		apb(1, 12'h000, 32'h001f_ffff, 4'h1);
		egr_m[7:0] = 8'hff;
		apb(0, 12'h000, 0, 0);
		chk_reg("strobe write", egr_m, rd & 32'h001f_ffff);
		$display("test strobe_write done");
		for (i = 0; i < 60; i++) begin
			a = rnd();
			a[1:0] = (a[1:0] == 2'h3) ? 2'h2 : a[1:0];
			wreg(12'h000, a);
			apb(0, 12'h000, 0, 0);
			chk_reg("egress readback", a & 32'h001f_ffff, rd & 32'h001f_ffff);
			a = rnd();
			a[1:0] = (a[1:0] == 2'h3) ? 2'h1 : a[1:0];
			wreg(12'h004, a);
			wreg(12'h008, rnd());
			wreg(12'h00c, rnd());
			wreg(12'h010, rnd());
			a = rnd();
			if (!ctrl_m[0] && a[8:7] == 2'h3) a[8:7] = 2'h1;
			send(a[5], a[6], a[8:7], a[10:9], a[12:11]);
		end
		$display("test random_flows done");
		for (i = 0; i < 8; i++)
			send(0, i[2], i[1:0], 2'h2, 2'h1);
		$display("test nomatch_classes done");
		clk_en <= 0;
		send(1, 0, 2'h1, 2'h2, 2'h1);
		clk_en <= 1;
		$display("test clock_enable done");
		apb(0, 12'h014, 0, 0);
		chk_reg("lookup counter", n_lookups, rd);
		$display("test status_count done");
		close_out;
	end
	initial begin
		#1_000_000;
		n_errors++;
		close_out;
	end
	task automatic close_out;
		chk_reg("frames at mac", exp_frames, frames);
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
endmodule
